// [verilog/lcsg_pkg.sv]
/*
 * Constants for the life-cycle security gate: register offsets, field
 * positions, life-cycle encodings, reset values and timing counts.
 * Assumes a single 200 MHz system clock and a plain register port.
 */
// Contract
// - Life-cycle held as fixed 3-bit codes
// - Life cycle only moves forward
// - Illegal life-cycle code holds chip in reset
// - Tool flash access only delivery or OEM; code also grants it in-field once a censored part is unlocked
// - Censored in-field refuses tool flash access
// - Censored access needs correct tool password; code grants debug in supplier and serial boot outside in-field without it
// - Password is 256 bits wide
// - Censor enable and password from config records
// - Judge challenges, keep security and access state
// - Debug, serial boot, flash gated by stage
package lcsg_pkg;

	localparam int unsigned PWD_BITS  = 256;
	localparam int unsigned WORD_BITS = 32;
	localparam int unsigned PWD_WORDS = PWD_BITS / WORD_BITS;

	// Life-cycle encodings
	localparam logic [2:0] LC_SUPPLIER = 3'h6;
	localparam logic [2:0] LC_DELIVERY = 3'h3;
	localparam logic [2:0] LC_OEM      = 3'h2;
	localparam logic [2:0] LC_FIELD    = 3'h7;
	localparam logic [2:0] LC_ANALYSIS = 3'h0;

	// Register byte offsets
	localparam logic [7:0] OFS_LC_STATE = 8'h00;
	localparam logic [7:0] OFS_LC_ADV   = 8'h04;
	localparam logic [7:0] OFS_ACCESS   = 8'h08;
	localparam logic [7:0] OFS_CHAL_CMD = 8'h0c;
	localparam logic [7:0] OFS_PWD_BASE = 8'h20;
	localparam logic [7:0] OFS_PWD_LAST = 8'h3c;

	// Access status field positions
	localparam int unsigned BIT_DEBUG    = 0;
	localparam int unsigned BIT_SBOOT    = 1;
	localparam int unsigned BIT_FLASH    = 2;
	localparam int unsigned BIT_UNLOCK   = 3;
	localparam int unsigned BIT_CENSOR   = 4;
	localparam int unsigned BIT_FAIL     = 5;
	localparam int unsigned BIT_REJECT   = 6;
	localparam int unsigned BIT_ILLEGAL  = 7;

	// Command field positions
	localparam int unsigned BIT_CMD_CHECK = 0;
	localparam int unsigned BIT_CMD_LOCK  = 1;

	// Reset hold stretch after an illegal code is seen
	localparam int unsigned HOLD_NS     = 100;
	localparam int unsigned CLK_MHZ     = 200;
	localparam int unsigned HOLD_CYCLES = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  HOLD_CNT    = 8'(HOLD_CYCLES);

	localparam logic [WORD_BITS-1:0] ZERO_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		LCSG_CHK_IDLE,
		LCSG_CHK_CMP,
		LCSG_CHK_DONE
	} lcsg_chk_e;

endpackage

// [verilog/lcsg_order.sv]
/*
 * Life-cycle order helper: maps a code to its rank in the forward
 * sequence and flags codes that are not legal.
 * Assumes pure combinational use inside the gate.
 */
`timescale 1ns/10ps
`default_nettype none
module lcsg_order
(
	input  wire logic [2:0] lcCode,
	output logic      [2:0] lcRank,
	output logic            lcLegal
);

	// ********************
	// Rank lookup
	// ********************
	always_comb
	begin
		lcLegal = 1'b1;
		unique case (lcCode)
			lcsg_pkg::LC_SUPPLIER: lcRank = 3'h0;
			lcsg_pkg::LC_DELIVERY: lcRank = 3'h1;
			lcsg_pkg::LC_OEM:      lcRank = 3'h2;
			lcsg_pkg::LC_FIELD:    lcRank = 3'h3;
			lcsg_pkg::LC_ANALYSIS: lcRank = 3'h4;
			default:
			begin
				lcRank  = 3'h7;
				lcLegal = 1'b0;
			end
		endcase
	end

endmodule
`default_nettype wire

// [verilog/lcsg_pwd_cmp.sv]
/*
 * Password comparator: per-word equality of presented and stored
 * passwords, reduced to one match flag.
 * Assumes both passwords are stable while the result is sampled.
 */
`timescale 1ns/10ps
`default_nettype none
module lcsg_pwd_cmp
(
	input  wire logic [lcsg_pkg::PWD_BITS-1:0] pwdGiven,
	input  wire logic [lcsg_pkg::PWD_BITS-1:0] pwdStored,
	output logic                               pwdMatch
);

	logic [lcsg_pkg::PWD_WORDS-1:0] wordEq;

	// ********************
	// Word compare
	// ********************
	genvar w;
	generate
		for (w = 0; w < lcsg_pkg::PWD_WORDS; w++)
		begin : gWord
			assign wordEq[w] = pwdGiven[w*32 +: 32] == pwdStored[w*32 +: 32];
		end
	endgenerate

	assign pwdMatch = &wordEq;

endmodule
`default_nettype wire

// [verilog/lcsg_gate.sv]
/*
 * Life-cycle security gate top: holds the life-cycle state, allows
 * forward moves only, holds reset on an illegal code, judges tool
 * password challenges and gates debug, serial boot and tool flash access.
 * Assumes configuration record values are stable after reset and that
 * the register master follows the plain strobe protocol.
 */
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module lcsg_gate
(
	input  wire logic                          clk_sys,
	input  wire logic                          arst_n,
	input  wire logic [2:0]                    cfgLcCode,
	input  wire logic                          cfgLcValid,
	input  wire logic                          cfgCensorEn,
	input  wire logic [lcsg_pkg::PWD_BITS-1:0] cfgPassword,
	input  wire logic [7:0]                    regAddr,
	input  wire logic [31:0]                   regWdata,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic      [31:0]                   regRdata,
	output logic                               chipResetHold,
	output logic                               debugEnable,
	output logic                               serialBootEnable,
	output logic                               toolFlashEnable
);

	// ********************
	// State
	// ********************
	logic [2:0]                    lc_q,        lc_d;
	logic                          lcLoaded_q,  lcLoaded_d;
	logic                          censor_q,    censor_d;
	logic [lcsg_pkg::PWD_BITS-1:0] stored_q,    stored_d;
	logic [lcsg_pkg::PWD_BITS-1:0] given_q,     given_d;
	lcsg_pkg::lcsg_chk_e           chk_q,       chk_d;
	logic                          unlock_q,    unlock_d;
	logic                          fail_q,      fail_d;
	logic                          reject_q,    reject_d;
	logic                          illegal_q,   illegal_d;
	logic [7:0]                    hold_q,      hold_d;
	logic                          holdOut_q,   holdOut_d;
	logic                          dbg_q,       dbg_d;
	logic                          sboot_q,     sboot_d;
	logic                          flash_q,     flash_d;
	logic [31:0]                   rdata_q,     rdata_d;

	logic [2:0] curRank;
	logic       curLegal;
	logic [2:0] newRank;
	logic       newLegal;
	logic       pwdMatch;

	// ********************
	// Submodules
	// ********************
	lcsg_order uCurOrder
	(
		.lcCode  (lc_q),
		.lcRank  (curRank),
		.lcLegal (curLegal)
	);

	lcsg_order uNewOrder
	(
		.lcCode  (regWdata[2:0]),
		.lcRank  (newRank),
		.lcLegal (newLegal)
	);

	lcsg_pwd_cmp uCmp
	(
		.pwdGiven  (given_q),
		.pwdStored (stored_q),
		.pwdMatch  (pwdMatch)
	);

	// ********************
	// Register decode
	// ********************
	logic wrAdv;
	logic wrCmd;
	logic wrPwd;
	logic [2:0] pwdIdx;

	assign wrAdv  = regWr && regAddr == lcsg_pkg::OFS_LC_ADV;
	assign wrCmd  = regWr && regAddr == lcsg_pkg::OFS_CHAL_CMD;
	assign wrPwd  = regWr && regAddr >= lcsg_pkg::OFS_PWD_BASE
		&& regAddr <= lcsg_pkg::OFS_PWD_LAST && regAddr[1:0] == 2'h0;
	assign pwdIdx = 3'(regAddr[4:2]);

	// ********************
	// Life cycle and record load
	// ********************
	always_comb
	begin
		lc_d       = lc_q;
		lcLoaded_d = lcLoaded_q;
		censor_d   = censor_q;
		stored_d   = stored_q;
		reject_d   = reject_q;
		if (!lcLoaded_q && cfgLcValid)
		begin
			lc_d       = cfgLcCode;
			censor_d   = cfgCensorEn;
			stored_d   = cfgPassword;
			lcLoaded_d = 1'b1;
		end
		else if (lcLoaded_q && wrAdv)
		begin
			if (curLegal && newLegal && newRank > curRank)
			begin
				lc_d     = regWdata[2:0];
				reject_d = 1'b0;
			end
			else
			begin
				reject_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lc_q       <= lcsg_pkg::LC_ANALYSIS;
			lcLoaded_q <= 1'b0;
			censor_q   <= 1'b1;
			stored_q   <= '0;
			reject_q   <= 1'b0;
		end
		else
		begin
			lc_q       <= lc_d;
			lcLoaded_q <= lcLoaded_d;
			censor_q   <= censor_d;
			stored_q   <= stored_d;
			reject_q   <= reject_d;
		end
	end

	// ********************
	// Password challenge
	// ********************
	always_comb
	begin
		given_d  = given_q;
		chk_d    = chk_q;
		unlock_d = unlock_q;
		fail_d   = fail_q;
		if (wrCmd && regWdata[lcsg_pkg::BIT_CMD_LOCK])
		begin
			unlock_d = 1'b0;
		end
		case (chk_q)
			lcsg_pkg::LCSG_CHK_IDLE:
			begin
				if (wrCmd && regWdata[lcsg_pkg::BIT_CMD_CHECK]
					&& !regWdata[lcsg_pkg::BIT_CMD_LOCK])
				begin
					chk_d = lcsg_pkg::LCSG_CHK_CMP;
				end
			end
			lcsg_pkg::LCSG_CHK_CMP:
			begin
				unlock_d = pwdMatch;
				fail_d   = !pwdMatch;
				chk_d    = lcsg_pkg::LCSG_CHK_DONE;
			end
			lcsg_pkg::LCSG_CHK_DONE:
			begin
				given_d = '0;
				chk_d   = lcsg_pkg::LCSG_CHK_IDLE;
			end
			default:
			begin
				chk_d = lcsg_pkg::LCSG_CHK_IDLE;
			end
		endcase
		if (wrPwd)
		begin
			given_d[pwdIdx*32 +: 32] = regWdata;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			given_q  <= '0;
			chk_q    <= lcsg_pkg::LCSG_CHK_IDLE;
			unlock_q <= 1'b0;
			fail_q   <= 1'b0;
		end
		else
		begin
			given_q  <= given_d;
			chk_q    <= chk_d;
			unlock_q <= unlock_d;
			fail_q   <= fail_d;
		end
	end

	// ********************
	// Gating terms
	// ********************
	logic devRank;
	logic censorLock;
	logic access;

	assign devRank    = lc_q == lcsg_pkg::LC_DELIVERY || lc_q == lcsg_pkg::LC_OEM;
	assign censorLock = censor_q && !unlock_q;
	assign access     = lcLoaded_q && curLegal && !holdOut_q;

	// ********************
	// Reset hold and feature gating
	// ********************
	always_comb
	begin
		illegal_d = 1'b0;
		hold_d    = hold_q;
		if (lcLoaded_q && !curLegal)
		begin
			illegal_d = 1'b1;
		end
		if (illegal_q)
		begin
			hold_d = lcsg_pkg::HOLD_CNT;
		end
		else if (hold_q != 8'h00)
		begin
			hold_d = hold_q - 8'h01;
		end
		holdOut_d = 1'b0;
		dbg_d     = 1'b0;
		sboot_d   = 1'b0;
		flash_d   = 1'b0;
		if (!lcLoaded_q || illegal_q || hold_q != 8'h00)
		begin
			holdOut_d = 1'b1;
		end
		if (access)
		begin
			if (!censorLock || lc_q == lcsg_pkg::LC_SUPPLIER)
			begin
				dbg_d = 1'b1;
			end
			if (lc_q != lcsg_pkg::LC_FIELD || !censorLock)
			begin
				sboot_d = 1'b1;
			end
			if (devRank)
			begin
				flash_d = 1'b1;
			end
			else if (lc_q == lcsg_pkg::LC_FIELD && censor_q && unlock_q)
			begin
				flash_d = 1'b1;
			end
		end
		if (censorLock && lc_q == lcsg_pkg::LC_FIELD)
		begin
			flash_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			illegal_q <= 1'b0;
			hold_q    <= 8'h00;
			holdOut_q <= 1'b1;
			dbg_q     <= 1'b0;
			sboot_q   <= 1'b0;
			flash_q   <= 1'b0;
		end
		else
		begin
			illegal_q <= illegal_d;
			hold_q    <= hold_d;
			holdOut_q <= holdOut_d;
			dbg_q     <= dbg_d;
			sboot_q   <= sboot_d;
			flash_q   <= flash_d;
		end
	end

	// ********************
	// Register read
	// ********************
	always_comb
	begin
		rdata_d = lcsg_pkg::ZERO_WORD;
		if (regRd)
		begin
			case (regAddr)
				lcsg_pkg::OFS_LC_STATE:
				begin
					rdata_d = {29'h0, lc_q};
				end
				lcsg_pkg::OFS_ACCESS:
				begin
					rdata_d[lcsg_pkg::BIT_DEBUG]   = dbg_q;
					rdata_d[lcsg_pkg::BIT_SBOOT]   = sboot_q;
					rdata_d[lcsg_pkg::BIT_FLASH]   = flash_q;
					rdata_d[lcsg_pkg::BIT_UNLOCK]  = unlock_q;
					rdata_d[lcsg_pkg::BIT_CENSOR]  = censor_q;
					rdata_d[lcsg_pkg::BIT_FAIL]    = fail_q;
					rdata_d[lcsg_pkg::BIT_REJECT]  = reject_q;
					rdata_d[lcsg_pkg::BIT_ILLEGAL] = illegal_q;
				end
				lcsg_pkg::OFS_LC_ADV,
				lcsg_pkg::OFS_CHAL_CMD:
				begin
					rdata_d = lcsg_pkg::ZERO_WORD;
				end
				default:
				begin
					rdata_d = lcsg_pkg::ZERO_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_q <= lcsg_pkg::ZERO_WORD;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign regRdata         = rdata_q;
	assign chipResetHold    = holdOut_q;
	assign debugEnable      = dbg_q;
	assign serialBootEnable = sboot_q;
	assign toolFlashEnable  = flash_q;

endmodule
`default_nettype wire

// [bench/lcsg_gate_checker.sv]
/* Port checker for the life-cycle gate.
   Bound to every lcsg_gate instance. */
`timescale 1ns/10ps
`default_nettype none
module lcsg_gate_checker
(
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic [2:0]  cfgLcCode,
	input wire logic        cfgLcValid,
	input wire logic        cfgCensorEn,
	input wire logic [7:0]  regAddr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        chipResetHold,
	input wire logic        debugEnable,
	input wire logic        serialBootEnable,
	input wire logic        toolFlashEnable
);
	wire logic [2:0] en = {toolFlashEnable, serialBootEnable, debugEnable};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	function automatic logic legal(input logic [2:0] c);
		return c inside {3'h6, 3'h3, 3'h2, 3'h7, 3'h0};
	endfunction
	a_hold_gates_off:
	assert property (chipResetHold |-> en == 3'h0) else $error("enable during hold");
	a_illegal_holds:
	assert property ($rose(cfgLcValid) && !legal(cfgLcCode) |-> chipResetHold[*8])
		else $error("illegal code not held");
	a_legal_release:
	assert property ($rose(cfgLcValid) && legal(cfgLcCode) |-> ##[1:6] !chipResetHold)
		else $error("legal code still held");
	a_rdata_idle:
	assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("read data not idle");
	a_unmapped_zero:
	assert property ($past(regRd) && $past(regAddr) > 8'h3c |-> regRdata == 32'h0)
		else $error("unmapped read not zero");
	a_lc_read_legal:
	assert property ($past(regRd) && $past(regAddr) == 8'h00 && !chipResetHold
		|-> legal(regRdata[2:0]) && regRdata[31:3] == 29'h0) else $error("bad stage read");
	a_status_match:
	assert property ($past(regRd) && $past(regAddr) == 8'h08 && $stable(en)
		&& $past(en, 2) == en |-> regRdata[2:0] == en) else $error("status mismatch");
	a_flash_stage:
	assert property ($past(regRd, 3) && $past(regAddr, 3) == 8'h00 && toolFlashEnable
		|-> $past(regRdata[2:0], 2) inside {3'h3, 3'h2, 3'h7}) else $error("flash stage");
	a_sboot_censor:
	assert property (!serialBootEnable && !chipResetHold && !$past(chipResetHold, 3)
		|-> cfgCensorEn) else $error("serial boot off uncensored");
	a_debug_open:
	assert property (!chipResetHold && !$past(chipResetHold, 3) && !cfgCensorEn
		|-> debugEnable) else $error("debug off uncensored");
	c_unlock: cover property ($rose(toolFlashEnable) && cfgCensorEn);
	c_held: cover property (chipResetHold && cfgLcValid);
	c_reject: cover property ($past(regRd) && regRdata[6]);
endmodule
bind lcsg_gate lcsg_gate_checker lcsg_gate_checker_i (.clk_sys(clk_sys), .arst_n(arst_n),
	.cfgLcCode(cfgLcCode), .cfgLcValid(cfgLcValid), .cfgCensorEn(cfgCensorEn),
	.regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
	.chipResetHold(chipResetHold), .debugEnable(debugEnable),
	.serialBootEnable(serialBootEnable), .toolFlashEnable(toolFlashEnable));
`default_nettype wire

// [bench/lcsg_tool_model.sv]
/* Debug tool model: writes 8 password words then a check command.
   Shares the register port through a bench mux while busy. */
`timescale 1ns/10ps
`default_nettype none
module lcsg_tool_model
(
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	input  wire logic         start,
	input  wire logic [255:0] pwd,
	output logic              busy,
	output logic [7:0]        tAddr,
	output logic [31:0]       tWdata,
	output logic              tWr
);
	logic [3:0] n;
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy <= 1'b0;
			tWr <= 1'b0;
			n <= 4'h0;
			tAddr <= 8'h00;
			tWdata <= 32'h0;
		end
		else if (!busy)
		begin
			busy <= start;
			n <= 4'h0;
		end
		else
		begin
			tWr <= n != 4'h9;
			busy <= n != 4'h9;
			tAddr <= n < 4'h8 ? 8'h20 + {3'h0, n[2:0], 2'h0} : 8'h0c;
			tWdata <= n < 4'h8 ? pwd[n[2:0]*32 +: 32] :
				(n == 4'h8 ? 32'h1 : ~tWdata);
			n <= n + 4'h1;
		end
	end
endmodule
`default_nettype wire

// [bench/test_lcsg_gate.sv]
/* Self-checking bench for the life-cycle gate.
   Needs the gate, its package, checker and tool model. */
`timescale 1ns/10ps
`default_nettype none
module test_lcsg_gate;
	logic         clk_sys = 1'b0;
	logic         arst_n = 1'b0;
	logic [2:0]   cfgLcCode = 3'h0;
	logic         cfgLcValid = 1'b0;
	logic         cfgCensorEn = 1'b0;
	logic [255:0] pwd = {8{32'h5a3c_96e1}};
	logic [255:0] tPwd = 256'h0;
	logic [7:0]   bAddr = 8'h00;
	logic [31:0]  bWdata = 32'h0;
	logic         bWr = 1'b0;
	logic         bRd = 1'b0;
	logic         start = 1'b0;
	logic [7:0]   tAddr;
	logic [31:0]  tWdata;
	logic [31:0]  rdat;
	logic         tWr, busy, hold, dbg, sbt, fl;
	int           num_errors = 0;
	int           cmp_count = 0;
	always #2.5 clk_sys = ~clk_sys;
	lcsg_gate lcsg_gate_i (.clk_sys(clk_sys), .arst_n(arst_n), .cfgLcCode(cfgLcCode),
		.cfgLcValid(cfgLcValid), .cfgCensorEn(cfgCensorEn), .cfgPassword(pwd),
		.regAddr(busy ? tAddr : bAddr), .regWdata(busy ? tWdata : bWdata),
		.regWr(busy ? tWr : bWr), .regRd(bRd), .regRdata(rdat), .chipResetHold(hold),
		.debugEnable(dbg), .serialBootEnable(sbt), .toolFlashEnable(fl));
	lcsg_tool_model lcsg_tool_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .start(start),
		.pwd(tPwd), .busy(busy), .tAddr(tAddr), .tWdata(tWdata), .tWr(tWr));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bWr <= 1'b1;
		bAddr <= a;
		bWdata <= d;
		@(posedge clk_sys);
		bWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bRd <= 1'b1;
		bAddr <= a;
		@(posedge clk_sys);
		bRd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic boot(input logic [2:0] c, input logic cen);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		cfgLcValid <= 1'b0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		cfgLcCode <= c;
		cfgCensorEn <= cen;
		repeat (2) @(posedge clk_sys);
		cfgLcValid <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask
	task automatic tool(input logic [255:0] p);
		@(posedge clk_sys);
		tPwd <= p;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		#1;
		for (int i = 0; busy && i < 20; i++) @(posedge clk_sys);
		chk("busy", 32'h0, 32'(busy));
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic t_illegal;
		logic [31:0] d;
		boot(3'h5, 1'b0);
		repeat (30) @(posedge clk_sys);
		#1 chk("hold", 32'h1, 32'(hold));
		chk("debug", 32'h0, 32'(dbg));
		rd(lcsg_pkg::OFS_ACCESS, d);
		chk("illegal", 32'h1, 32'(d[7]));
	endtask
	task automatic t_stages;
		logic [31:0] d;
		logic [2:0] cs [4] = '{3'h3, 3'h2, 3'h7, 3'h0};
		logic fx [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
		boot(lcsg_pkg::LC_SUPPLIER, 1'b0);
		chk("hold", 32'h0, 32'(hold));
		rd(lcsg_pkg::OFS_LC_STATE, d);
		chk("stage", 32'h6, d);
		chk("flash", 32'h0, 32'(fl));
		for (int i = 0; i < 4; i++)
		begin
			wr(lcsg_pkg::OFS_LC_ADV, {29'h0, cs[i]});
			repeat (4) @(posedge clk_sys);
			rd(lcsg_pkg::OFS_LC_STATE, d);
			chk("stage", {29'h0, cs[i]}, d);
			chk("flash", 32'(fx[i]), 32'(fl));
			chk("sboot", 32'h1, 32'(sbt));
			chk("debug", 32'h1, 32'(dbg));
		end
		wr(lcsg_pkg::OFS_LC_ADV, 32'h2);
		rd(lcsg_pkg::OFS_ACCESS, d);
		chk("reject", 32'h1, 32'(d[6]));
		rd(lcsg_pkg::OFS_LC_STATE, d);
		chk("stage", 32'h0, d);
		rd(8'h40, d);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_censor;
		logic [31:0] d;
		boot(lcsg_pkg::LC_FIELD, 1'b1);
		chk("flash", 32'h0, 32'(fl));
		chk("sboot", 32'h0, 32'(sbt));
		chk("debug", 32'h0, 32'(dbg));
		tool(pwd ^ {1'b1, 255'h0});
		rd(lcsg_pkg::OFS_ACCESS, d);
		chk("fail", 32'h1, 32'(d[5]));
		chk("censor", 32'h1, 32'(d[4]));
		chk("flash", 32'h0, 32'(fl));
		tool(pwd);
		rd(lcsg_pkg::OFS_ACCESS, d);
		chk("unlock", 32'h1, 32'(d[3]));
		chk("flash", 32'h1, 32'(fl));
		chk("debug", 32'h1, 32'(dbg));
		wr(lcsg_pkg::OFS_CHAL_CMD, 32'h2);
		repeat (4) @(posedge clk_sys);
		#1 chk("flash", 32'h0, 32'(fl));
		chk("debug", 32'h0, 32'(dbg));
		chk("sboot", 32'h0, 32'(sbt));
	endtask
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		num_errors++;
		end_sim;
	end
	initial
	begin
		t_illegal;
		t_stages;
		t_censor;
		end_sim;
	end
endmodule
`default_nettype wire
